// >>> design/stereo_glasses_sync.sv
// Functional notes
// (R1) Sync outputs follow stereo frames so shutters match displayed frames.
// (R2) Eye-sync level is a plain output for an external IR emitter.
// (R3) Optical mode: exactly one pulse per frame, inside the dark window; code gives none in the first optical frame.
// (R4) Optical mode: tell illumination driver when to light the pulse.
// (R5) Illumination stays off in the dark window except during the pulse.
// (R6) Pulse colour selectable; blue request is replaced by red.
// (R7) Eye select is one for left frames, zero for right frames.
// (R8) Eye select changes 1 ms before the vsync that starts the frame.
// (R9) Pulse sits near frame end; offset alternates between B and B+D.
// (R10) Pulse width 20 to 32 us; pulse spacing E above 2000 us.
// (R11) B above 500 us; D within 128 to 163 us.
// (R12) Second offset C is always B plus D.
// (R13) Input rate is twice source rate; 120 Hz nominal width 26 us.
// (R14) Lead, offsets and width are programmable core clock counts.
// (R15) Disabled or reset: eye select low, no pulses.
`timescale 1ns/1ps
`default_nettype none
module stereo_glasses_sync #(
    parameter stereo_sync_pkg::cnt_t LEAD_CYC = stereo_sync_pkg::LEAD_CYC_DEF,
    parameter stereo_sync_pkg::cnt_t E_CYC = stereo_sync_pkg::E_CYC_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // frame timing from the display pipeline
    input wire logic vsync_in,
    input wire logic next_left,
    // mode control
    input wire logic stereo_en,
    input wire logic link_mode,
    input wire stereo_sync_pkg::sync_cfg_s cfg,
    // glasses sync outputs
    output logic eye_select,
    output stereo_sync_pkg::illum_req_s illum_req
);
    import stereo_sync_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_PULSE,
        ST_DONE
    } pulse_state_e;

    function automatic cnt_t clamp_cnt(input cnt_t v, input cnt_t lo,
                                       input cnt_t hi);
        cnt_t r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    logic vsync_d_ff;
    logic frame_start;
    cnt_t pos;
    cnt_t period;
    logic period_valid;

    // (R1) frame edge timing
    assign frame_start = vsync_in & ~vsync_d_ff;

    // (R13) input rate measured; periods longer than CNT_MAX cycles saturate
    frame_period_meter u_meter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .frame_start(frame_start),
        .pos(pos),
        .period(period),
        .period_valid(period_valid)
    );

    // (R14) programmable cycle counts
    // (R11) limits on B and D
    cnt_t b_cyc, d_cyc, a_cyc, c_cyc, offset, pulse_start, lead_at;
    assign b_cyc = clamp_cnt(cfg.offset_b, B_MIN_CYC, CNT_MAX);
    assign d_cyc = clamp_cnt(cfg.delta_d, D_MIN_CYC, D_MAX_CYC);
    // (R10) width held to its window
    assign a_cyc = clamp_cnt(cfg.width, A_MIN_CYC, A_MAX_CYC);
    // (R12) second offset is B plus D
    assign c_cyc = b_cyc + d_cyc;

    logic alt_ff, nxt_alt;
    // (R9) offset alternates per frame
    assign offset = alt_ff ? c_cyc : b_cyc;
    assign pulse_start = period - offset;
    assign lead_at = period - LEAD_CYC;

    logic active;
    logic link_on;
    logic dark;
    assign active = stereo_en & period_valid;
    assign link_on = active & link_mode;
    // (R5) dark window runs to the end of the frame
    assign dark = link_on & (period > cfg.dark_len)
                  & (pos >= period - cfg.dark_len);

    pulse_state_e state_ff, nxt_state;
    cnt_t width_ff, nxt_width;
    cnt_t since_ff, nxt_since;
    logic eye_ff, nxt_eye;
    logic illum_ff, nxt_illum;
    color_e color_ff, nxt_color;

    always_comb begin
        nxt_state = state_ff;
        nxt_width = width_ff;
        nxt_alt = alt_ff;
        nxt_since = (since_ff >= E_CYC) ? since_ff : since_ff + CNT_ONE;
        nxt_eye = eye_ff;
        nxt_color = color_ff;
        // (R8) latch upcoming eye at the lead point
        if (active && period > LEAD_CYC && pos == lead_at) begin
            // (R7) one for left, zero for right
            nxt_eye = next_left;
        end
        // (R6) blue is substituted by red
        if (cfg.color == COLOR_BLUE) begin
            nxt_color = COLOR_RED;
        end else begin
            nxt_color = cfg.color;
        end
        case (state_ff)
            ST_IDLE: begin
                if (link_on && frame_start) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // (R3) one pulse, only while dark and spaced by E
                if (frame_start) begin
                    nxt_alt = ~alt_ff;
                end else if (pos == pulse_start && offset < period
                             && dark && since_ff >= E_CYC) begin
                    nxt_state = ST_PULSE;
                    nxt_width = CNT_ONE;
                    nxt_since = CNT_ZERO;
                end
            end
            ST_PULSE: begin
                // (R4) light request lasts the width count
                if (width_ff >= a_cyc) begin
                    nxt_state = ST_DONE;
                end else begin
                    nxt_width = width_ff + CNT_ONE;
                end
            end
            default: begin
                if (frame_start) begin
                    nxt_state = ST_WAIT;
                    nxt_alt = ~alt_ff;
                end
            end
        endcase
        // (R15) disabled forces quiet outputs
        if (!stereo_en) begin
            nxt_eye = 1'b0;
        end
        if (!link_on) begin
            nxt_state = ST_IDLE;
            nxt_alt = 1'b0;
        end
        // (R5) lamp off in the dark window except the pulse
        nxt_illum = !(dark && nxt_state != ST_PULSE)
                    || (nxt_state == ST_PULSE);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            vsync_d_ff <= 1'b0;
            state_ff <= ST_IDLE;
            width_ff <= CNT_ZERO;
            alt_ff <= 1'b0;
            since_ff <= CNT_ZERO;
            eye_ff <= 1'b0;
            illum_ff <= 1'b1;
            color_ff <= COLOR_RED;
        end else begin
            vsync_d_ff <= vsync_in;
            state_ff <= nxt_state;
            width_ff <= nxt_width;
            alt_ff <= nxt_alt;
            since_ff <= nxt_since;
            eye_ff <= nxt_eye;
            illum_ff <= nxt_illum;
            color_ff <= nxt_color;
        end
    end

    // (R2) eye sync driven straight from its flop
    assign eye_select = eye_ff;
    assign illum_req.sync_light = (state_ff == ST_PULSE);
    assign illum_req.illum_en = illum_ff;
    assign illum_req.color = color_ff;

    // helper: pulse length and pulses per frame
    cnt_t len_ff;
    logic [1:0] npulse_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            len_ff <= CNT_ZERO;
            npulse_ff <= 2'h0;
        end else begin
            len_ff <= illum_req.sync_light ? len_ff + CNT_ONE : CNT_ZERO;
            if (frame_start) begin
                npulse_ff <= 2'h0;
            end else if (nxt_state == ST_PULSE && state_ff != ST_PULSE
                         && npulse_ff != 2'h3) begin
                npulse_ff <= npulse_ff + 2'h1;
            end
        end
    end

    chk_eye_quiet: assert property ( // (R15)
        @(posedge core_clk) disable iff (!rst_n)
        !stereo_en |=> !eye_select && !illum_req.sync_light)
        else $error("eye select or pulse active while disabled");

    chk_eye_lead: assert property ( // (R8)
        @(posedge core_clk) disable iff (!rst_n)
        $changed(eye_select) && $past(stereo_en)
        |-> $past(pos) == $past(lead_at))
        else $error("eye select changed away from lead point");

    chk_eye_level: assert property ( // (R7)
        @(posedge core_clk) disable iff (!rst_n)
        active && period > LEAD_CYC && pos == lead_at
        |=> eye_select == $past(next_left))
        else $error("eye select does not follow upcoming eye");

    chk_pulse_width: assert property ( // (R10)
        @(posedge core_clk) disable iff (!rst_n)
        $fell(illum_req.sync_light) && $past(stereo_en)
        |-> $past(len_ff) + CNT_ONE == $past(a_cyc))
        else $error("sync pulse width wrong");

    chk_one_pulse: assert property ( // (R3)
        @(posedge core_clk) disable iff (!rst_n)
        npulse_ff <= 2'h1)
        else $error("more than one pulse in a frame");

    chk_pulse_dark: assert property ( // (R5)
        @(posedge core_clk) disable iff (!rst_n)
        $rose(illum_req.sync_light) |-> $past(dark) ##1 illum_req.illum_en)
        else $error("pulse started outside dark window");

    chk_pulse_place: assert property ( // (R9)
        @(posedge core_clk) disable iff (!rst_n)
        $rose(illum_req.sync_light)
        |-> $past(pos) == $past(period) - $past(offset))
        else $error("pulse not at its frame offset");

    chk_c_sum: assert property ( // (R12)
        @(posedge core_clk) disable iff (!rst_n)
        alt_ff |-> offset == b_cyc + d_cyc && d_cyc >= D_MIN_CYC
        && d_cyc <= D_MAX_CYC && b_cyc >= B_MIN_CYC)
        else $error("alternate offset not B plus D");

    chk_spacing: assert property ( // (R10)
        @(posedge core_clk) disable iff (!rst_n)
        $rose(illum_req.sync_light) |-> $past(since_ff) >= E_CYC)
        else $error("pulses closer than spacing E");

    chk_no_blue: assert property ( // (R6)
        @(posedge core_clk) disable iff (!rst_n)
        illum_req.color != COLOR_BLUE)
        else $error("blue pulse colour issued");

    chk_lamp_dark: assert property ( // (R5)
        @(posedge core_clk) disable iff (!rst_n)
        $past(dark) && !illum_req.sync_light |-> !illum_req.illum_en)
        else $error("lamp on in dark window outside pulse");

    chk_lamp_pulse: assert property ( // (R4)
        @(posedge core_clk) disable iff (!rst_n)
        illum_req.sync_light |-> illum_req.illum_en)
        else $error("lamp off during sync pulse");

    chk_width_max: assert property ( // (R10)
        @(posedge core_clk) disable iff (!rst_n)
        illum_req.sync_light |-> len_ff < A_MAX_CYC)
        else $error("sync pulse longer than allowed");

    chk_alt_flip: assert property ( // (R9)
        @(posedge core_clk) disable iff (!rst_n)
        frame_start && link_on
        && (state_ff == ST_WAIT || state_ff == ST_DONE)
        |=> alt_ff != $past(alt_ff))
        else $error("pulse offset did not alternate");

    chk_color_pass: assert property ( // (R6)
        @(posedge core_clk) disable iff (!rst_n)
        cfg.color != COLOR_BLUE |=> illum_req.color == $past(cfg.color))
        else $error("pulse colour does not follow request");

    chk_ir_quiet: assert property ( // (R3)
        @(posedge core_clk) disable iff (!rst_n)
        !link_on |=> !illum_req.sync_light)
        else $error("sync pulse outside optical mode");

endmodule // stereo_glasses_sync
`default_nettype wire

// >>> design/stereo_sync_pkg.sv
package stereo_sync_pkg;

    // core clock rate
    localparam int CLK_MHZ = 40;

    localparam int CNT_W = 20;
    typedef logic [CNT_W-1:0] cnt_t;

    // eye-select lead ahead of vsync
    localparam int LEAD_TIME_US = 1000;
    localparam cnt_t LEAD_CYC_DEF = cnt_t'(LEAD_TIME_US * CLK_MHZ);

    // pulse width A, limits and nominal at 120 Hz
    localparam int A_MIN_US = 20;
    localparam int A_MAX_US = 32;
    localparam int A_NOM_120_NS = 26000;
    localparam cnt_t A_MIN_CYC = cnt_t'(A_MIN_US * CLK_MHZ);
    localparam cnt_t A_MAX_CYC = cnt_t'(A_MAX_US * CLK_MHZ);
    localparam cnt_t A_NOM_CYC = cnt_t'((A_NOM_120_NS * CLK_MHZ) / 1000);

    // base offset B must exceed this
    localparam int B_MIN_US = 500;
    localparam cnt_t B_MIN_CYC = cnt_t'(B_MIN_US * CLK_MHZ + 1);
    localparam cnt_t B_NOM_CYC = cnt_t'(B_MIN_CYC + cnt_t'(20'h003E8));

    // delta D, limits and nominal at 98 Hz
    localparam int D_MIN_US = 128;
    localparam int D_MAX_US = 163;
    localparam int D_NOM_98_NS = 161600;
    localparam cnt_t D_MIN_CYC = cnt_t'(D_MIN_US * CLK_MHZ);
    localparam cnt_t D_MAX_CYC = cnt_t'(D_MAX_US * CLK_MHZ);
    localparam cnt_t D_NOM_CYC = cnt_t'((D_NOM_98_NS * CLK_MHZ) / 1000);

    // spacing E must exceed this
    localparam int E_MIN_US = 2000;
    localparam cnt_t E_CYC_DEF = cnt_t'(E_MIN_US * CLK_MHZ + 1);

    localparam cnt_t CNT_MAX = cnt_t'(20'hFFFFF);
    localparam cnt_t CNT_ZERO = cnt_t'(20'h00000);
    localparam cnt_t CNT_ONE = cnt_t'(20'h00001);

    typedef enum logic [1:0] {
        COLOR_RED,
        COLOR_GREEN,
        COLOR_BLUE
    } color_e;

    typedef struct packed {
        cnt_t offset_b;
        cnt_t delta_d;
        cnt_t width;
        cnt_t dark_len;
        color_e color;
    } sync_cfg_s;

    typedef struct packed {
        logic sync_light;
        logic illum_en;
        color_e color;
    } illum_req_s;

endpackage

// >>> design/frame_period_meter.sv
`timescale 1ns/1ps
`default_nettype none
module frame_period_meter (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // frame start strobe
    input wire logic frame_start,
    // measured timing
    output stereo_sync_pkg::cnt_t pos,
    output stereo_sync_pkg::cnt_t period,
    output logic period_valid
);
    import stereo_sync_pkg::*;

    cnt_t pos_ff, nxt_pos;
    cnt_t period_ff, nxt_period;
    logic seen_ff, nxt_seen;
    logic valid_ff, nxt_valid;

    always_comb begin
        nxt_pos = pos_ff;
        nxt_period = period_ff;
        nxt_seen = seen_ff;
        nxt_valid = valid_ff;
        if (frame_start) begin
            nxt_pos = CNT_ZERO;
            nxt_seen = 1'b1;
            // first strobe has no previous frame to measure
            if (seen_ff) begin
                nxt_period = (pos_ff == CNT_MAX) ? CNT_MAX : pos_ff + CNT_ONE;
                nxt_valid = 1'b1;
            end
        end else if (pos_ff != CNT_MAX) begin
            nxt_pos = pos_ff + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pos_ff <= CNT_ZERO;
            period_ff <= CNT_ZERO;
            seen_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            pos_ff <= nxt_pos;
            period_ff <= nxt_period;
            seen_ff <= nxt_seen;
            valid_ff <= nxt_valid;
        end
    end

    assign pos = pos_ff;
    assign period = period_ff;
    assign period_valid = valid_ff;

endmodule // frame_period_meter
`default_nettype wire

// >>> sim/glasses_partner.sv
`timescale 1ns/1ps
`default_nettype none
module glasses_partner (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // sync seen at the emitter side
    input wire logic vsync_in,
    input wire stereo_sync_pkg::illum_req_s illum_req,
    // figures of the last frame
    output stereo_sync_pkg::cnt_t pulses,
    output stereo_sync_pkg::cnt_t start_pos,
    output stereo_sync_pkg::cnt_t width
);
    import stereo_sync_pkg::*;
    cnt_t pos_ff, cur_ff, run_ff;
    logic vs_ff, sl_ff;
    always @(posedge core_clk) begin
        vs_ff <= vsync_in;
        sl_ff <= illum_req.sync_light;
        pos_ff <= pos_ff + CNT_ONE;
        run_ff <= illum_req.sync_light ? run_ff + CNT_ONE : CNT_ZERO;
        if (sl_ff && !illum_req.sync_light) begin
            width <= run_ff;
        end
        if (illum_req.sync_light && !sl_ff) begin
            cur_ff <= cur_ff + CNT_ONE;
            start_pos <= pos_ff;
        end
        if (vsync_in && !vs_ff) begin
            pulses <= cur_ff;
            cur_ff <= CNT_ZERO;
            pos_ff <= CNT_ZERO;
        end
        if (!rst_n) begin
            cur_ff <= CNT_ZERO;
            run_ff <= CNT_ZERO;
            pulses <= CNT_ZERO;
        end
    end
endmodule // glasses_partner
`default_nettype wire

// >>> sim/stereo_glasses_sync_test.sv
`timescale 1ns/1ps
`default_nettype none
module stereo_glasses_sync_test;
    import stereo_sync_pkg::*;
    // frame kept just above B+D so the run stays short
    localparam int FRAME_CYC = 25800;
    localparam cnt_t D_SET = 20'h01400;
    typedef struct {
        logic left;
        logic eye;
        cnt_t npulse;
    } row_s;
    row_s rows[3];
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic vsync_in = 1'b0;
    logic next_left = 1'b0;
    logic stereo_en = 1'b0;
    logic link_mode = 1'b0;
    sync_cfg_s cfg;
    logic eye_select;
    illum_req_s illum_req;
    cnt_t pulses, start_pos, width, prev_pos;
    int failures = 0;
    int n_tests = 0;
    always #12.5 core_clk = ~core_clk;
    stereo_glasses_sync #(.LEAD_CYC(20'h00014), .E_CYC(20'h0000A))
        u_stereo_glasses_sync (.core_clk(core_clk), .rst_n(rst_n),
        .vsync_in(vsync_in), .next_left(next_left), .stereo_en(stereo_en),
        .link_mode(link_mode), .cfg(cfg), .eye_select(eye_select),
        .illum_req(illum_req));
    glasses_partner u_glasses_partner (.core_clk(core_clk), .rst_n(rst_n),
        .vsync_in(vsync_in), .illum_req(illum_req), .pulses(pulses),
        .start_pos(start_pos), .width(width));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic frame();
        vsync_in = 1'b1;
        tick(1);
        vsync_in = 1'b0;
        tick(FRAME_CYC - 1);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_cnt(input cnt_t got, input cnt_t exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %0d", $time, m, got);
        end
    endtask
    task automatic chk_pulse();
        cnt_t gap;
        gap = (start_pos > prev_pos) ? start_pos - prev_pos
                                     : prev_pos - start_pos;
        chk_cnt(pulses, CNT_ONE, "pulse count");
        chk_cnt(width, A_MIN_CYC, "pulse width");
        chk_cnt(gap, D_SET, "offset step");
        prev_pos = start_pos;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        cfg = '{offset_b: 20'h04E21, delta_d: D_SET, width: 20'h00320,
                dark_len: 20'h06338, color: COLOR_BLUE};
        rows[0] = '{1'b1, 1'b1, CNT_ZERO};
        // pulses lag a frame: first pulse frame is reported by row 2
        rows[1] = '{1'b0, 1'b0, CNT_ZERO};
        rows[2] = '{1'b1, 1'b1, CNT_ONE};
        tick(2);
        rst_n = 1'b1;
        stereo_en = 1'b1;
        link_mode = 1'b1;
        frame();
        for (int i = 0; i < 3; i++) begin
            next_left = rows[i].left;
            frame();
            chk_bit(eye_select, rows[i].eye, "eye level");
            chk_cnt(pulses, rows[i].npulse, "frame pulses");
            chk_bit(illum_req.illum_en, 1'b0, "lamp dark");
            if (i == 1) begin
                prev_pos = start_pos;
            end
            if (i == 2) begin
                chk_cnt(width, A_MIN_CYC, "pulse width");
            end
            $display("row %0d done", i);
        end
        vsync_in = 1'b1;
        tick(1);
        vsync_in = 1'b0;
        tick(1);
        chk_pulse();
        chk_cnt(cnt_t'(illum_req.color), cnt_t'(COLOR_RED), "blue");
        cfg.color = COLOR_GREEN;
        tick(2);
        chk_cnt(cnt_t'(illum_req.color), cnt_t'(COLOR_GREEN), "green");
        $display("colour test done");
        link_mode = 1'b0;
        tick(2);
        chk_bit(illum_req.illum_en, 1'b1, "ir mode lamp");
        chk_bit(illum_req.sync_light, 1'b0, "ir mode pulse");
        chk_bit(eye_select, 1'b1, "ir mode eye");
        $display("ir mode test done");
        stereo_en = 1'b0;
        tick(1);
        chk_bit(eye_select, 1'b0, "eye after disable");
        chk_bit(illum_req.sync_light, 1'b0, "light after disable");
        $display("disable test done");
        stereo_en = 1'b1;
        rst_n = 1'b0;
        tick(1);
        chk_bit(eye_select, 1'b0, "eye in reset");
        chk_bit(illum_req.illum_en, 1'b1, "illum in reset");
        chk_cnt(cnt_t'(illum_req.color), cnt_t'(COLOR_RED), "rst col");
        $display("reset test done");
        stop_test();
    end
endmodule // stereo_glasses_sync_test
`default_nettype wire
